// ==== pkg/smm_pkg.sv ====
package smm_pkg;

   // Slave addresses, 7 bit
   localparam logic [6:0] ADDR_DEFAULT    = 7'h2e;
   localparam logic [6:0] ADDR_SEL_LO     = 7'h2c;
   localparam logic [6:0] ADDR_SEL_HI     = 7'h2d;
   localparam logic [6:0] ADDR_ALERT_RESP = 7'h0c;

   // Register pointer values
   localparam logic [7:0] REG_VALUE_BASE = 8'h20;
   localparam logic [7:0] REG_LIMLO_BASE = 8'h30;
   localparam logic [7:0] REG_LIMHI_BASE = 8'h38;
   localparam logic [7:0] REG_CFG        = 8'h40;
   localparam logic [7:0] REG_STATUS     = 8'h41;
   localparam logic [7:0] REG_VID        = 8'h43;
   localparam logic [7:0] REG_OFFS_BASE  = 8'h70;
   localparam logic [7:0] REG_MASK       = 8'h74;

   // Configuration fields
   localparam int CFG_MON_BIT   = 0;
   localparam int CFG_ALERT_BIT = 1;
   localparam int CFG_BUS_TIMEOUT_DISABLE_BIT = 6;

   // Reset values
   localparam logic [7:0] CFG_RST   = 8'h00;
   localparam logic [7:0] MASK_RST  = 8'h00;
   localparam logic [7:0] LIMLO_RST = 8'h00;
   localparam logic [7:0] LIMHI_RST = 8'hff;

   // Channels: 0..1 voltage, 2..3 temperature
   localparam int NCH        = 4;
   localparam int NTEMP      = 2;
   localparam int TEMP_FIRST = 2;

   // Bus idle timeout
   localparam int unsigned CLK_HZ      = 40_000_000;
   localparam int unsigned TOUT_MIN_MS = 15;
   localparam int unsigned TOUT_MAX_MS = 35;
   localparam int unsigned TOUT_MIN_CYC = (CLK_HZ / 1000) * TOUT_MIN_MS;
   localparam int unsigned TOUT_MAX_CYC = (CLK_HZ / 1000) * TOUT_MAX_MS;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ADDR     = 3'b001,
      ST_ACK_ADDR = 3'b011,
      ST_WRITE    = 3'b010,
      ST_ACK_WR   = 3'b110,
      ST_READ     = 3'b111,
      ST_RACK     = 3'b101
   } smm_state_e;

   typedef struct packed {
      logic                       scl_s1;
      logic                       scl_s2;
      logic                       scl_d;
      logic                       sda_s1;
      logic                       sda_s2;
      logic                       sda_d;
      logic [4:0]                 vid_s1;
      logic [4:0]                 vid_s2;
      logic [1:0]                 strap_s1;
      logic [1:0]                 strap_s2;
      logic                       latched;
      logic [6:0]                 own_addr;
      smm_state_e                 state;
      logic [3:0]                 cnt;
      logic [7:0]                 sr;
      logic [7:0]                 tx;
      logic                       first;
      logic                       alert_reply;
      logic                       sda_drive;
      logic [7:0]                 ptr;
      logic [7:0]                 cfg;
      logic [7:0]                 mask;
      logic [7:0]                 status;
      logic [4:0]                 vid;
      logic [NCH-1:0][7:0]        value;
      logic [NCH-1:0][7:0]        limlo;
      logic [NCH-1:0][7:0]        limhi;
      logic [NTEMP-1:0][7:0]      offs;
      logic [1:0]                 chan;
      logic [19:0]                tout;
      logic                       fan2_drive;
   } smm_regs_s;

endpackage

// ==== logic/smm_port.sv ====
`timescale 1ns/1ps
module smm_port
   import smm_pkg::*;
#(
   parameter int unsigned TOUT_CYC = TOUT_MIN_CYC
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       reset_n,
   input  wire logic       clk_en,
   // Two-wire bus
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n,
   // Address straps and their release
   input  wire logic       addr_strap_enable_pin,
   input  wire logic       addr_strap_select_pin,
   output logic            strap_released,
   // Fan 2 PWM or alert pin
   input  wire logic       fan2_pwm_level,
   output logic            fan2_pwm_or_alert_pin,
   output logic            fan2_pwm_or_alert_oe_n,
   // Processor VID inputs
   input  wire logic       proc_vid_bit0,
   input  wire logic       proc_vid_bit1,
   input  wire logic       proc_vid_bit2,
   input  wire logic       proc_vid_bit3,
   input  wire logic       proc_vid_bit4,
   // Measurement sequencer
   input  wire logic       meas_done,
   input  wire logic [7:0] meas_value,
   output logic            meas_enable,
   output logic [1:0]      meas_chan
);

   smm_regs_s s;
   smm_regs_s n;

   logic       scl_rise;
   logic       scl_fall;
   logic       start_seen;
   logic       stop_seen;
   logic [6:0] strap_addr;
   logic [7:0] reg_rd;
   logic [7:0] tx_next;
   logic       alert_low;
   logic       bus_timeout_disable;

   assign scl_rise   = s.scl_s2 & ~s.scl_d;
   assign scl_fall   = ~s.scl_s2 & s.scl_d;
   assign start_seen = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
   assign stop_seen  = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
   assign bus_timeout_disable = s.cfg[CFG_BUS_TIMEOUT_DISABLE_BIT];
   assign alert_low  = s.cfg[CFG_ALERT_BIT] & s.fan2_drive;

   // Used only at the first start; later strap changes are ignored
   // Address from the synchronised strap levels
   always_comb begin
      if (s.strap_s2[1]) begin
         strap_addr = ADDR_DEFAULT;
      end else if (s.strap_s2[0]) begin
         strap_addr = ADDR_SEL_HI;
      end else begin
         strap_addr = ADDR_SEL_LO;
      end
   end

   // Register read mux; reserved locations read zero
   always_comb begin
      reg_rd = 8'h00;
      if (s.ptr == REG_CFG) begin
         reg_rd = s.cfg;
      end else if (s.ptr == REG_STATUS) begin
         reg_rd = s.status;
      end else if (s.ptr == REG_VID) begin
         reg_rd = {3'b000, s.vid};
      end else if (s.ptr == REG_MASK) begin
         reg_rd = s.mask;
      end else if (s.ptr[7:2] == REG_VALUE_BASE[7:2]) begin
         reg_rd = s.value[s.ptr[1:0]];
      end else if (s.ptr[7:2] == REG_LIMLO_BASE[7:2]) begin
         reg_rd = s.limlo[s.ptr[1:0]];
      end else if (s.ptr[7:2] == REG_LIMHI_BASE[7:2]) begin
         reg_rd = s.limhi[s.ptr[1:0]];
      end else if (s.ptr[7:1] == REG_OFFS_BASE[7:1]) begin
         reg_rd = s.offs[s.ptr[0]];
      end
   end

   // Alert response returns our own address in the upper seven bits
   assign tx_next = s.alert_reply ? {s.own_addr, 1'b0} : reg_rd;

   always_comb begin
      logic [7:0] v;
      logic       out_lim;
      logic [7:0] st_set;
      logic [7:0] st_clr;
      logic [1:0] ti;
      v       = 8'h00;
      out_lim = 1'b0;
      st_set  = 8'h00;
      st_clr  = 8'h00;
      ti      = 2'd0;
      n       = s;

      // Two-stage synchronisers for every pin input
      n.scl_s1   = scl_in;
      n.scl_s2   = s.scl_s1;
      n.scl_d    = s.scl_s2;
      n.sda_s1   = sda_in;
      n.sda_s2   = s.sda_s1;
      n.sda_d    = s.sda_s2;
      n.vid_s1   = {proc_vid_bit4, proc_vid_bit3, proc_vid_bit2,
                    proc_vid_bit1, proc_vid_bit0};
      n.vid_s2   = s.vid_s1;
      n.strap_s1 = {addr_strap_enable_pin, addr_strap_select_pin};
      n.strap_s2 = s.strap_s1;
      n.vid      = s.vid_s2;

      // Measurement sequence, offset and limit compare
      // Temperatures compare as two's complement, voltages unsigned
      if (meas_done && s.cfg[CFG_MON_BIT]) begin
         v = meas_value;
         if (s.chan >= 2'(TEMP_FIRST)) begin
            ti = s.chan - 2'(TEMP_FIRST);
            v  = meas_value + s.offs[ti[0]];
            out_lim = ($signed(v) < $signed(s.limlo[s.chan])) ||
                      ($signed(v) > $signed(s.limhi[s.chan]));
         end else begin
            out_lim = (v < s.limlo[s.chan]) || (v > s.limhi[s.chan]);
         end
         n.value[s.chan] = v;
         st_set[s.chan]  = out_lim;
         n.chan          = s.chan + 2'd1;
      end

      // Bus state machine
      if (start_seen) begin
         // Repeated start also lands here
         if (!s.latched) begin
            n.latched  = 1'b1;
            n.own_addr = strap_addr;
         end
         n.state     = ST_ADDR;
         n.cnt       = 4'd0;
         n.sda_drive = 1'b0;
         n.alert_reply = 1'b0;
      end else if (stop_seen) begin
         n.state     = ST_IDLE;
         n.sda_drive = 1'b0;
      end else begin
         case (s.state)
            ST_IDLE: begin
               n.sda_drive = 1'b0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  n.sr  = {s.sr[6:0], s.sda_s2};
                  n.cnt = s.cnt + 4'd1;
               end else if (scl_fall && s.cnt == 4'd8) begin
                  if (s.sr[7:1] == s.own_addr) begin
                     n.sda_drive = 1'b1;
                     n.state     = ST_ACK_ADDR;
                  end else if (s.sr[7:1] == ADDR_ALERT_RESP &&
                               s.sr[0] && alert_low) begin
                     // Alert reply is only given on a read with alert low
                     n.sda_drive = 1'b1;
                     n.alert_reply = 1'b1;
                     n.state     = ST_ACK_ADDR;
                  end else begin
                     n.state = ST_IDLE;
                  end
               end
            end
            ST_ACK_ADDR: begin
               if (scl_fall) begin
                  n.cnt = 4'd0;
                  if (s.sr[0]) begin
                     // Read uses pointer as left by earlier writes
                     n.tx        = tx_next;
                     n.sda_drive = ~tx_next[7];
                     n.state     = ST_READ;
                     if (!s.alert_reply && s.ptr == REG_STATUS) begin
                        st_clr = s.status;
                     end
                  end else begin
                     n.sda_drive = 1'b0;
                     // First byte of every write is the pointer
                     n.first     = 1'b1;
                     n.state     = ST_WRITE;
                  end
               end
            end
            ST_WRITE: begin
               if (scl_rise) begin
                  n.sr  = {s.sr[6:0], s.sda_s2};
                  n.cnt = s.cnt + 4'd1;
               end else if (scl_fall && s.cnt == 4'd8) begin
                  n.sda_drive = 1'b1;
                  n.first     = 1'b0;
                  n.state     = ST_ACK_WR;
                  if (s.first) begin
                     n.ptr = s.sr;
                  end else if (s.ptr == REG_CFG) begin
                     n.cfg = s.sr;
                  end else if (s.ptr == REG_MASK) begin
                     n.mask = s.sr;
                  end else if (s.ptr[7:2] == REG_LIMLO_BASE[7:2]) begin
                     n.limlo[s.ptr[1:0]] = s.sr;
                  end else if (s.ptr[7:2] == REG_LIMHI_BASE[7:2]) begin
                     n.limhi[s.ptr[1:0]] = s.sr;
                  end else if (s.ptr[7:1] == REG_OFFS_BASE[7:1]) begin
                     n.offs[s.ptr[0]] = s.sr;
                  end
               end
            end
            ST_ACK_WR: begin
               // Any number of further bytes may follow
               if (scl_fall) begin
                  n.sda_drive = 1'b0;
                  n.cnt       = 4'd0;
                  n.state     = ST_WRITE;
               end
            end
            ST_READ: begin
               if (scl_fall) begin
                  if (s.cnt == 4'd7) begin
                     // Release for the master's acknowledge bit
                     n.sda_drive = 1'b0;
                     n.state     = ST_RACK;
                  end else begin
                     n.tx        = {s.tx[6:0], 1'b0};
                     n.sda_drive = ~s.tx[6];
                     n.cnt       = s.cnt + 4'd1;
                  end
               end
            end
            ST_RACK: begin
               // Master no-acknowledge ends the read
               if (scl_rise && s.sda_s2) begin
                  n.state = ST_IDLE;
               end else if (scl_fall) begin
                  n.tx        = tx_next;
                  n.sda_drive = ~tx_next[7];
                  n.cnt       = 4'd0;
                  n.state     = ST_READ;
                  if (!s.alert_reply && s.ptr == REG_STATUS) begin
                     st_clr = s.status;
                  end
               end
            end
            default: begin
               n.state     = ST_IDLE;
               n.sda_drive = 1'b0;
            end
         endcase
      end

      // Idle-bus timeout; any clock or data edge restarts the count
      // The 20-bit counter keeps the limit below 2**20 cycles
      if (s.state == ST_IDLE || scl_rise || scl_fall ||
          (s.sda_s2 != s.sda_d)) begin
         n.tout = 20'd0;
      end else begin
         n.tout = s.tout + 20'd1;
         if (!bus_timeout_disable && s.tout >= 20'(TOUT_CYC - 1)) begin
            n.state     = ST_IDLE;
            n.sda_drive = 1'b0;
         end
      end

      // Bits clear when the byte is loaded, so a read cut short
      // by a timeout still loses them
      // A new event wins over a read-clear in the same cycle
      n.status = (s.status & ~st_clr) | st_set;

      // Alert follows unmasked status; pin shows PWM otherwise
      if (s.cfg[CFG_ALERT_BIT]) begin
         n.fan2_drive = |(n.status & ~s.mask);
      end else begin
         n.fan2_drive = ~fan2_pwm_level;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         // Pins idle high, so no false edge follows reset
         s          <= '0;
         s.scl_s1   <= 1'b1;
         s.scl_s2   <= 1'b1;
         s.scl_d    <= 1'b1;
         s.sda_s1   <= 1'b1;
         s.sda_s2   <= 1'b1;
         s.sda_d    <= 1'b1;
         s.strap_s1 <= 2'b11;
         s.strap_s2 <= 2'b11;
         s.own_addr <= ADDR_DEFAULT;
         s.state    <= ST_IDLE;
         s.cfg      <= CFG_RST;
         s.mask     <= MASK_RST;
         s.limlo    <= {NCH{LIMLO_RST}};
         s.limhi    <= {NCH{LIMHI_RST}};
      end else if (clk_en) begin
         s <= n;
      end
   end

   // Open-drain outputs only ever pull low
   assign sda_out                = 1'b0;
   assign sda_oe_n               = ~s.sda_drive;
   assign fan2_pwm_or_alert_pin  = 1'b0;
   assign fan2_pwm_or_alert_oe_n = ~s.fan2_drive;
   // Fan logic may take the strap pins once this is high
   assign strap_released         = s.latched;
   assign meas_enable            = s.cfg[CFG_MON_BIT];
   assign meas_chan              = s.chan;

endmodule

// ==== bench/smm_port_properties.sv ====
`timescale 1ns/1ps
module smm_port_properties (
   // Watched ports
   input wire logic       sys_clk,
   input wire logic       reset_n,
   input wire logic       clk_en,
   input wire logic       scl_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_n,
   input wire logic       strap_released,
   input wire logic       fan2_pwm_or_alert_pin,
   input wire logic       meas_done,
   input wire logic       meas_enable,
   input wire logic [1:0] meas_chan
);
   default clocking cb @(posedge sys_clk);
   endclocking

   AST_RST_IDLE: assert property (
      !reset_n && clk_en |=> sda_oe_n && !strap_released && !meas_enable
         && meas_chan == 2'h0)
      else $error("outputs not idle after reset");
   AST_SDA_OD: assert property (disable iff (!reset_n)
      sda_out == 1'b0)
      else $error("data pin value not low");
   AST_ALERT_OD: assert property (disable iff (!reset_n)
      fan2_pwm_or_alert_pin == 1'b0)
      else $error("fan2 pin value not low");
   AST_NO_DRIVE_UNLATCHED: assert property (disable iff (!reset_n)
      !strap_released |-> sda_oe_n)
      else $error("data driven before address latched");
   AST_STRAP_HOLD: assert property (disable iff (!reset_n)
      strap_released && clk_en |=> strap_released)
      else $error("strap release dropped");
   AST_SDA_CHG_SCL_LOW: assert property (disable iff (!reset_n)
      $changed(sda_oe_n) |-> !scl_in)
      else $error("data drive changed while clock high");
   AST_DRIVE_STANDS: assert property (disable iff (!reset_n)
      $fell(sda_oe_n) && clk_en |=> !sda_oe_n [*3])
      else $error("data drive too short");
   AST_CHAN_ADV: assert property (disable iff (!reset_n)
      meas_done && meas_enable && clk_en
         |=> meas_chan == $past(meas_chan) + 2'h1)
      else $error("channel did not advance");
   AST_CHAN_HOLD: assert property (disable iff (!reset_n)
      !meas_done && meas_enable |=> $stable(meas_chan))
      else $error("channel moved without a result");
endmodule

bind smm_port smm_port_properties chk_u (.sys_clk, .reset_n, .clk_en,
   .scl_in, .sda_out, .sda_oe_n, .strap_released, .fan2_pwm_or_alert_pin,
   .meas_done, .meas_enable, .meas_chan);

// ==== bench/smm_bus_master.sv ====
`timescale 1ns/1ps
module smm_bus_master (
   // Clock and bus wires
   input  wire logic sys_clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_m
);
   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Also serves as repeated start from a low clock
   task automatic start;
      sda_m <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_m <= 1'b0;
      tick(4);
   endtask

   task automatic xfer(input logic [7:0] d, input logic mack,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= -1; i--) begin
         scl <= 1'b0;
         tick(2);
         sda_m <= (i < 0) ? mack : d[i];
         tick(2);
         scl <= 1'b1;
         tick(3);
         if (i < 0) ack = sda_line;
         else q[i] = sda_line;
         tick(1);
      end
   endtask

   task automatic park;
      scl <= 1'b0;
   endtask

   task automatic stop;
      scl <= 1'b0;
      tick(2);
      sda_m <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_m <= 1'b1;
      tick(4);
   endtask
endmodule

// ==== bench/tb_smm_port.sv ====
`timescale 1ns/1ps
module tb_smm_port;
   import smm_pkg::*;
   // Short idle timeout keeps the run brief
   localparam int unsigned TO = 200;
   logic            sys_clk = 1'b0;
   logic            reset_n = 1'b0;
   logic            clk_en  = 1'b1;
   logic            str_en  = 1'b1;
   logic            str_sel = 1'b0;
   logic            pwm     = 1'b1;
   logic            mdone   = 1'b0;
   logic [7:0]      mval    = 8'h00;
   logic [4:0]      vid     = 5'h15;
   logic [6:0]      own     = ADDR_DEFAULT;
   int              n_errors = 0;
   int              n_tests  = 0;
   wire logic       scl, sda_m, sda_out, sda_oe_n, rel, f2, f2_oe_n, men;
   wire logic [1:0] mch;
   // Pulled-up wire: released reads high
   wire logic       sda = sda_m & (sda_oe_n | sda_out);

   initial forever #12.5 sys_clk = ~sys_clk;

   smm_port #(.TOUT_CYC(TO)) dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
      .clk_en(clk_en), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .addr_strap_enable_pin(str_en),
      .addr_strap_select_pin(str_sel), .strap_released(rel),
      .fan2_pwm_level(pwm), .fan2_pwm_or_alert_pin(f2),
      .fan2_pwm_or_alert_oe_n(f2_oe_n), .proc_vid_bit0(vid[0]),
      .proc_vid_bit1(vid[1]), .proc_vid_bit2(vid[2]),
      .proc_vid_bit3(vid[3]), .proc_vid_bit4(vid[4]), .meas_done(mdone),
      .meas_value(mval), .meas_enable(men), .meas_chan(mch));
   smm_bus_master m_u (.sys_clk(sys_clk), .sda_line(sda), .scl(scl),
      .sda_m(sda_m));

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic do_reset;
      reset_n <= 1'b0;
      tick(3);
      reset_n <= 1'b1;
      tick(3);
   endtask

   task automatic wr(input logic [7:0] p, input logic [7:0] d, input int n);
      logic [7:0] q;
      logic       a;
      m_u.start();
      m_u.xfer({own, 1'b0}, 1'b1, q, a);
      chk({7'h0, a}, 8'h00);
      m_u.xfer(p, 1'b1, q, a);
      chk({7'h0, a}, 8'h00);
      for (int i = 0; i < n; i++) begin
         m_u.xfer(d, 1'b1, q, a);
         chk({7'h0, a}, 8'h00);
      end
      m_u.stop();
   endtask

   task automatic rd(input logic [6:0] ad, output logic [7:0] q);
      logic a;
      m_u.start();
      m_u.xfer({ad, 1'b1}, 1'b1, q, a);
      chk({7'h0, a}, 8'h00);
      m_u.xfer(8'hff, 1'b1, q, a);
      m_u.stop();
   endtask

   task automatic rdp(input logic [7:0] p, input logic [7:0] exp);
      logic [7:0] q;
      wr(p, 8'h00, 0);
      rd(own, q);
      chk(q, exp);
   endtask

   task automatic t_addr;
      logic [7:0] q;
      logic       a;
      for (int k = 0; k < 3; k++) begin
         str_en  <= (k == 0);
         str_sel <= (k == 2);
         own = (k == 0) ? ADDR_DEFAULT : (k == 1) ? ADDR_SEL_LO : ADDR_SEL_HI;
         do_reset();
         chk({7'h0, rel}, 8'h00);
         chk({7'h0, sda_oe_n}, 8'h01);
         wr(REG_LIMLO_BASE, 8'h11, 1);
         chk({7'h0, rel}, 8'h01);
         str_en  <= ~str_en;
         str_sel <= ~str_sel;
         rd(own, q);
         chk(q, 8'h11);
         m_u.start();
         m_u.xfer({own ^ 7'h01, 1'b0}, 1'b1, q, a);
         chk({7'h0, a}, 8'h01);
         m_u.stop();
      end
      $display("test addr done");
   endtask

   task automatic t_rw;
      logic [7:0] q;
      wr(REG_LIMHI_BASE, 8'h10, 3);
      rd(own, q);
      chk(q, 8'h10);
      rd(own, q);
      chk(q, 8'h10);
      rdp(REG_VID, {3'h0, vid});
      $display("test rw done");
   endtask

   task automatic t_tout;
      logic [7:0] q;
      logic       a;
      // Timeout disabled: a parked read must keep driving
      wr(REG_CFG, 8'h40, 1);
      m_u.start();
      m_u.xfer({own, 1'b1}, 1'b1, q, a);
      m_u.park();
      tick(TO + 20);
      chk({7'h0, sda_oe_n}, 8'h00);
      m_u.xfer(8'hff, 1'b1, q, a);
      chk(q, 8'h40);
      m_u.stop();
      wr(REG_CFG, 8'h00, 1);
      wr(REG_LIMHI_BASE, 8'h00, 0);
      m_u.start();
      m_u.xfer({own, 1'b1}, 1'b1, q, a);
      m_u.park();
      tick(8);
      chk({7'h0, sda_oe_n}, 8'h00);
      tick(TO + 20);
      chk({7'h0, sda_oe_n}, 8'h01);
      m_u.stop();
      rd(own, q);
      chk(q, 8'h10);
      $display("test timeout done");
   endtask

   task automatic t_mon;
      logic [7:0] q;
      logic       a;
      pwm <= 1'b0;
      tick(3);
      chk({7'h0, f2_oe_n}, 8'h00);
      pwm <= 1'b1;
      tick(3);
      chk({7'h0, f2_oe_n}, 8'h01);
      wr(REG_OFFS_BASE, 8'h05, 1);
      wr(REG_CFG, 8'h03, 1);
      chk({7'h0, men}, 8'h01);
      for (int c = 0; c < 3; c++) begin
         chk({6'h0, mch}, c[7:0]);
         mval  <= (c == 0) ? 8'h20 : (c == 1) ? 8'h00 : 8'h10;
         mdone <= 1'b1;
         tick(1);
         mdone <= 1'b0;
         tick(2);
      end
      // Frozen clock enable: a result pulse must leave no trace
      clk_en <= 1'b0;
      mval   <= 8'hff;
      mdone  <= 1'b1;
      tick(1);
      mdone  <= 1'b0;
      tick(2);
      clk_en <= 1'b1;
      chk({6'h0, mch}, 8'h03);
      chk({7'h0, f2_oe_n}, 8'h00);
      rdp(REG_VALUE_BASE, 8'h20);
      rdp(REG_VALUE_BASE + 8'h02, 8'h15);
      m_u.start();
      m_u.xfer({ADDR_ALERT_RESP, 1'b1}, 1'b1, q, a);
      chk({7'h0, a}, 8'h00);
      m_u.xfer(8'hff, 1'b1, q, a);
      chk(q, {own, 1'b0});
      m_u.stop();
      wr(REG_MASK, 8'h05, 1);
      tick(3);
      chk({7'h0, f2_oe_n}, 8'h01);
      rdp(REG_STATUS, 8'h05);
      rd(own, q);
      chk(q, 8'h00);
      $display("test monitor done");
   endtask

   initial begin
      t_addr();
      t_rw();
      t_tout();
      t_mon();
      report_and_stop();
   end

   initial begin
      #2_000_000;
      n_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      report_and_stop();
   end
endmodule
